// File: hdl/flsr_top.sv
// Status register, write protection and two-step memory reset of a serial flash.
//
// Behaviour
// - Reset memory acts only when reset-enable was the command just before it.
// - Any other command between reset-enable and reset memory cancels the reset.
// - Identification read: address 00h gives maker code first, 01h device code.
// - Field lengths count link clocks; address grows to four bytes in 4-byte mode.
// - Busy flag is 1 during program, erase or status write, else 0.
// - Write-enable command sets the write-enable latch.
// - Program and erase are ignored while the write-enable latch is 0.
// - Write-enable latch clears when a program or erase finishes.
// - Program or erase on a protected area is dropped and clears the latch.
// - Four protect-level bits, set only by status write, guard program and erase.
// - Chip erase runs only when all protect-level bits are 0.
// - Quad-enable 0 ignores quad commands; upper lanes are write-protect and spare.
// - Quad-enable 1 accepts all commands and makes upper pins data lanes.
// - Quad-enable 1 disables the high-performance mode.
// - Hardware protection needs the write-disable bit set and write-protect low.
// - Hardware protection refuses status write; disable and protect bits read-only.
`timescale 1ns/10ps
module flsr_top
  import flsr_pkg::*;
#(
  parameter int P_ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial link pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_si,
  input wire logic i_wp_n_lane2,
  output logic o_so,
  output logic o_so_oe,
  // Address width chosen by the configuration logic
  input wire logic i_addr_4byte,
  // Status and mode
  output logic [7:0] o_status,
  output logic o_lane23_data,
  output logic o_fast_mode_off,
  // Array operation request
  output logic o_op_start,
  output flsr_op_t o_op_kind,
  output logic [31:0] o_op_addr,
  output logic o_mem_reset
);
  typedef enum logic [2:0] {
    FS_IDLE = 3'b000,
    FS_CMD = 3'b001,
    FS_BODY = 3'b010
  } flsr_state_t;

  // A block is protected when it lies in the top 2**(level-1) blocks.
  function automatic logic prot_hit(input logic [3:0] level, input logic [BLK_W-1:0] blk);
    logic [BLK_W:0] first;
    first = '0;
    if (level == 4'h0) begin
      prot_hit = 1'b0;
    end else if (level > 4'h8) begin
      prot_hit = 1'b1;
    end else begin
      first = (BLK_W+1)'(1 << BLK_W) - (BLK_W+1)'(1 << (level - 4'h1));
      prot_hit = {1'b0, blk} >= first;
    end
  endfunction

  logic rst_meta_r;
  logic rst_n_s;
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic wp_n_s;
  logic sclk_prev_r;
  logic cs_prev_r;
  logic rise;
  logic fall;
  logic frame_end;
  flsr_state_t state_r;
  logic [6:0] shift_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] opcode_r;
  logic [31:0] addr_r;
  logic [7:0] data0_r;
  logic byte_done;
  logic [7:0] byte_val;
  logic [7:0] cur_op;
  logic [2:0] naddr;
  logic [7:0] out_shift_r;
  logic id_dev_r;
  logic latch_r;
  logic [3:0] bp_r;
  logic quad_r;
  logic swd_r;
  logic arm_r;
  logic [7:0] write_status_command_pend_r;
  flsr_op_t run_kind_r;
  logic busy;
  logic done;
  logic hw_prot;
  logic [7:0] status_now;
  logic tmr_start;
  logic [TMR_W-1:0] tmr_cycles;
  logic do_reset;
  flsr_op_t exec_kind;
  logic exec_drop;

  // The reset is released through two flops so every flop leaves reset together.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_s <= rst_meta_r;
    end
  end

  flsr_sync #(
    .W(4)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n_s),
    .i_d({i_cs_n, i_sclk, i_si, i_wp_n_lane2}),
    .o_q({cs_n_s, sclk_s, si_s, wp_n_s})
  );

  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_s;
      cs_prev_r <= cs_n_s;
    end
  end

  assign rise = sclk_s & ~sclk_prev_r & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_r & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_prev_r;
  assign byte_done = rise && (bit_cnt_r == 3'd7);
  assign byte_val = {shift_r, si_s};
  assign cur_op = (byte_cnt_r == 3'd0) ? byte_val : opcode_r;
  assign naddr = i_addr_4byte ? 3'(ADDR_BYTES_4) : 3'(ADDR_BYTES_3);
  // The write-protect function of lane two exists only while quad mode is off.
  assign hw_prot = swd_r & ~wp_n_s & ~quad_r;
  // Busy stays up through the finishing cycle so it drops together with the latch.
  assign status_now = {swd_r, quad_r, bp_r, latch_r, busy | done};

  // Frame state and bit assembly.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= FS_IDLE;
      shift_r <= '0;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
    end else begin
      if (cs_n_s) begin
        state_r <= FS_IDLE;
        bit_cnt_r <= '0;
        byte_cnt_r <= '0;
      end else begin
        case (state_r)
          FS_IDLE: begin
            state_r <= FS_CMD;
          end
          FS_CMD: begin
            if (byte_done) begin
              state_r <= FS_BODY;
            end
          end
          FS_BODY: begin
            state_r <= FS_BODY;
          end
          default: begin
            state_r <= FS_IDLE;
          end
        endcase
        if (rise) begin
          shift_r <= byte_val[6:0];
          bit_cnt_r <= bit_cnt_r + 3'd1;
        end
        if (byte_done && byte_cnt_r != 3'd7) begin
          byte_cnt_r <= byte_cnt_r + 3'd1;
        end
      end
    end
  end

  // Opcode, address and first data byte of the frame.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      opcode_r <= OPC_IDLE;
      addr_r <= '0;
      data0_r <= '0;
    end else if (byte_done) begin
      if (byte_cnt_r == 3'd0) begin
        opcode_r <= byte_val;
      end else if (byte_cnt_r == 3'd1) begin
        // The first address byte clears what an earlier frame left behind.
        addr_r <= {24'h000000, byte_val};
      end else if (byte_cnt_r <= naddr) begin
        addr_r <= {addr_r[23:0], byte_val};
      end
      if (byte_cnt_r == 3'd1) begin
        data0_r <= byte_val;
      end
    end
  end

  // Serial output: status repeats for a status read, identification bytes alternate.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      out_shift_r <= '0;
      id_dev_r <= 1'b0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      if (cs_n_s) begin
        o_so_oe <= 1'b0;
      end else if (byte_done) begin
        if (cur_op == OPC_RDSR) begin
          out_shift_r <= status_now;
          o_so_oe <= 1'b1;
        end else if (cur_op == OPC_ID_READ && byte_cnt_r >= 3'(ID_ADDR_BYTE)) begin
          if (byte_cnt_r == 3'(ID_ADDR_BYTE)) begin
            out_shift_r <= (byte_val == ID_ADDR_DEV_FIRST) ? DEV_ID : MFR_ID;
            id_dev_r <= (byte_val == ID_ADDR_DEV_FIRST);
          end else begin
            out_shift_r <= id_dev_r ? MFR_ID : DEV_ID;
            id_dev_r <= ~id_dev_r;
          end
          o_so_oe <= 1'b1;
        end
      end else if (fall && o_so_oe) begin
        o_so <= out_shift_r[7];
        out_shift_r <= {out_shift_r[6:0], 1'b0};
      end
    end
  end

  // Decide at the end of a whole-byte frame what the command does.
  always_comb begin
    exec_kind = OP_NONE;
    exec_drop = 1'b0;
    do_reset = 1'b0;
    tmr_cycles = TMR_W'(PROG_CYC);
    if (frame_end && bit_cnt_r == 3'd0 && byte_cnt_r != 3'd0) begin
      case (opcode_r)
        OPC_RST: begin
          do_reset = arm_r && byte_cnt_r == 3'd1;
        end
        OPC_STWR: begin
          if (!busy && latch_r && !hw_prot && byte_cnt_r >= 3'd2) begin
            exec_kind = OP_STWR;
            tmr_cycles = TMR_W'(STWR_CYC);
          end
        end
        OPC_PROG, OPC_QPP: begin
          if (!busy && latch_r && byte_cnt_r >= naddr + 3'd2
              && (opcode_r == OPC_PROG || quad_r)) begin
            exec_kind = OP_PROG;
            exec_drop = prot_hit(bp_r, addr_r[BLK_LO +: BLK_W]);
          end
        end
        OPC_SECT, OPC_HBE, OPC_BLK: begin
          if (!busy && latch_r && byte_cnt_r == naddr + 3'd1) begin
            exec_kind = (opcode_r == OPC_SECT) ? OP_SECT : (opcode_r == OPC_HBE) ? OP_HBE : OP_BLK;
            exec_drop = prot_hit(bp_r, addr_r[BLK_LO +: BLK_W]);
            tmr_cycles = TMR_W'(P_ERASE_CYCLES);
          end
        end
        OPC_CE: begin
          if (!busy && latch_r && byte_cnt_r == 3'd1) begin
            exec_kind = OP_CE;
            exec_drop = (bp_r != 4'h0);
            tmr_cycles = TMR_W'(P_ERASE_CYCLES);
          end
        end
        default: begin
          exec_kind = OP_NONE;
        end
      endcase
    end
  end

  assign tmr_start = (exec_kind != OP_NONE) && !exec_drop;

  flsr_busy_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(rst_n_s),
    .i_start(tmr_start),
    .i_cycles(tmr_cycles),
    .i_abort(do_reset),
    .o_busy(busy),
    .o_done(done)
  );

  // Reset-enable arming: only a reset memory directly after it may use it.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      arm_r <= 1'b0;
    end else if (frame_end && byte_cnt_r != 3'd0) begin
      arm_r <= (opcode_r == OPC_RST_ARM) && bit_cnt_r == 3'd0 && byte_cnt_r == 3'd1;
    end
  end

  // Write-enable latch; a finishing cycle clears it.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      latch_r <= 1'b0;
    end else if (do_reset) begin
      latch_r <= 1'b0;
    end else if (done) begin
      latch_r <= 1'b0;
    end else if (exec_drop) begin
      latch_r <= 1'b0;
    end else if (frame_end && bit_cnt_r == 3'd0 && byte_cnt_r == 3'd1 && !busy) begin
      if (opcode_r == OPC_WR_ON) begin
        latch_r <= 1'b1;
      end else if (opcode_r == OPC_WRDI) begin
        latch_r <= 1'b0;
      end
    end
  end

  // Non-volatile bits change only when a status write cycle completes.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      write_status_command_pend_r <= STATUS_RESET;
      run_kind_r <= OP_NONE;
      bp_r <= STATUS_RESET[ST_BP_HI:ST_BP_LO];
      quad_r <= STATUS_RESET[ST_QUAD];
      swd_r <= STATUS_RESET[ST_SWD];
    end else begin
      if (tmr_start) begin
        run_kind_r <= exec_kind;
        write_status_command_pend_r <= data0_r;
      end
      if (do_reset) begin
        run_kind_r <= OP_NONE;
      end else if (done && run_kind_r == OP_STWR) begin
        bp_r <= write_status_command_pend_r[ST_BP_HI:ST_BP_LO];
        quad_r <= write_status_command_pend_r[ST_QUAD];
        swd_r <= write_status_command_pend_r[ST_SWD];
        run_kind_r <= OP_NONE;
      end else if (done) begin
        run_kind_r <= OP_NONE;
      end
    end
  end

  // Registered outputs.
  always_ff @(posedge i_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_status <= STATUS_RESET;
      o_lane23_data <= 1'b0;
      o_fast_mode_off <= 1'b0;
      o_op_start <= 1'b0;
      o_op_kind <= OP_NONE;
      o_op_addr <= '0;
      o_mem_reset <= 1'b0;
    end else begin
      o_status <= status_now;
      o_lane23_data <= quad_r;
      o_fast_mode_off <= quad_r;
      o_op_start <= tmr_start && exec_kind != OP_STWR;
      o_mem_reset <= do_reset;
      if (tmr_start) begin
        o_op_kind <= exec_kind;
        o_op_addr <= addr_r;
      end
    end
  end
endmodule

// File: hdl/flsr_pkg.sv
// Shared constants and types of the flash status and reset control block.
package flsr_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Busy durations; longest times, so the cycle counts round down.
  localparam int STWR_TIME_NS = 5_000;
  localparam int PROG_TIME_NS = 10_000;
  localparam int ERASE_TIME_NS = 1_000_000;
  localparam int STWR_CYC = (STWR_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : STWR_TIME_NS / CLK_PERIOD_NS;
  localparam int PROG_CYC = (PROG_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYC = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 24;
  // Opcodes.
  localparam logic [7:0] OPC_IDLE = 8'h00;
  localparam logic [7:0] OPC_RST_ARM = 8'h66;
  localparam logic [7:0] OPC_RST = 8'h99;
  localparam logic [7:0] OPC_ID_READ = 8'h90;
  localparam logic [7:0] OPC_STWR = 8'h01;
  localparam logic [7:0] OPC_PROG = 8'h02;
  localparam logic [7:0] OPC_WRDI = 8'h04;
  localparam logic [7:0] OPC_RDSR = 8'h05;
  localparam logic [7:0] OPC_WR_ON = 8'h06;
  localparam logic [7:0] OPC_SECT = 8'h20;
  localparam logic [7:0] OPC_QPP = 8'h38;
  localparam logic [7:0] OPC_HBE = 8'h52;
  localparam logic [7:0] OPC_CE = 8'h60;
  localparam logic [7:0] OPC_BLK = 8'hD8;
  // Status register layout.
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 5;
  localparam int ST_QUAD = 6;
  localparam int ST_SWD = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Identification bytes; values are arbitrary.
  localparam logic [7:0] MFR_ID = 8'hA5;
  localparam logic [7:0] DEV_ID = 8'h3C;
  localparam logic [7:0] ID_ADDR_DEV_FIRST = 8'h01;
  localparam int ID_ADDR_BYTE = 3;
  // Protection granularity: 64 KB blocks, 256 of them.
  localparam int BLK_LO = 16;
  localparam int BLK_W = 8;
  localparam int ADDR_BYTES_3 = 3;
  localparam int ADDR_BYTES_4 = 4;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT = 3'b010,
    OP_HBE = 3'b011,
    OP_BLK = 3'b100,
    OP_CE = 3'b101,
    OP_STWR = 3'b110
  } flsr_op_t;
endpackage

// File: hdl/flsr_sync.sv
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/10ps
module flsr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// File: hdl/flsr_busy_timer.sv
// Down-counter that holds busy for the length of an internal write cycle.
`timescale 1ns/10ps
module flsr_busy_timer
  import flsr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic [TMR_W-1:0] i_cycles,
  input wire logic i_abort,
  // Status
  output logic o_busy,
  output logic o_done
);
  logic [TMR_W-1:0] cnt_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        cnt_r <= '0;
        o_busy <= 1'b0;
      end else if (i_start && !o_busy) begin
        cnt_r <= i_cycles;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (cnt_r <= TMR_W'(1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_r <= cnt_r - TMR_W'(1);
      end
    end
  end
endmodule

// File: tb/flsr_top_properties.sv
// Concurrent checks on the status, protection and reset outputs.
`timescale 1ns/10ps
module flsr_top_properties
  import flsr_pkg::*;
#(
  parameter int P_ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched pins
  input wire logic i_wp_n_lane2,
  input wire logic [7:0] o_status,
  input wire logic o_lane23_data,
  input wire logic o_fast_mode_off,
  input wire logic o_op_start,
  input wire flsr_op_t o_op_kind,
  input wire logic o_mem_reset
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_busy_soon;
    ##[1:3] o_status[ST_BUSY];
  endsequence
  sequence s_vol_clear;
    ##[1:3] (o_status[ST_LATCH:ST_BUSY] == 2'h0);
  endsequence
  sequence s_nv_hold;
    $stable(o_status[ST_SWD:ST_BP_LO]) [*3];
  endsequence
  property p_start_wel;
    o_op_start |-> o_status[ST_LATCH];
  endproperty
  property p_start_busy;
    o_op_start |-> s_busy_soon;
  endproperty
  property p_ce_bp;
    o_op_start && o_op_kind == OP_CE |-> o_status[ST_BP_HI:ST_BP_LO] == 4'h0;
  endproperty
  property p_done_wel;
    $fell(o_status[ST_BUSY]) |-> !o_status[ST_LATCH];
  endproperty
  property p_lane_qe;
    $rose(o_lane23_data) |-> ##[0:2] (o_status[ST_QUAD] && o_fast_mode_off);
  endproperty
  // The pin is synchronised, so protection is judged only once it has settled.
  property p_hw_ro;
    (o_status[ST_SWD] && !o_status[ST_QUAD] && !i_wp_n_lane2) [*8]
      |=> $stable(o_status[ST_SWD:ST_BP_LO]);
  endproperty
  property p_rst_vol;
    o_mem_reset |-> s_vol_clear;
  endproperty
  property p_rst_nv;
    o_mem_reset |=> s_nv_hold;
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("start without latch");
  a_start_busy: assert property (p_start_busy) else $error("no busy at start");
  a_ce_bp: assert property (p_ce_bp) else $error("chip erase while protected");
  a_done_wel: assert property (p_done_wel) else $error("latch kept at done");
  a_lane_qe: assert property (p_lane_qe) else $error("lane mode mismatch");
  a_hw_ro: assert property (p_hw_ro) else $error("protected bits changed");
  a_rst_vol: assert property (p_rst_vol) else $error("volatile bits kept");
  a_rst_nv: assert property (p_rst_nv) else $error("stored bits lost");
endmodule

bind flsr_top flsr_top_properties #(
  .P_ERASE_CYCLES(P_ERASE_CYCLES)
) i_flsr_top_properties (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wp_n_lane2(i_wp_n_lane2), .o_status(o_status),
  .o_lane23_data(o_lane23_data), .o_fast_mode_off(o_fast_mode_off), .o_op_start(o_op_start),
  .o_op_kind(o_op_kind), .o_mem_reset(o_mem_reset)
);

// File: tb/flsr_host.sv
// Behavioural single-lane host that frames whole bytes on the serial link.
`timescale 1ns/10ps
module flsr_host (
  // Clock
  input wire logic i_clk,
  // Link
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_si
);
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_si = 1'b1;
  end
  // The link clock stands low outside frames; inside, 4 cycles low then 4 high.
  // Read bits are taken late in the high phase, since the device answers slowly.
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int b = 8 * n - 1; b >= 0; b--) begin
      o_si = tx[b];
      o_sclk = 1'b0;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      rx[b] = i_so;
    end
    o_sclk = 1'b0;
    // A released line shows the inverse of its last value, not a held copy.
    o_si = ~o_si;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (8) @(negedge i_clk);
  endtask
endmodule

// File: tb/flsr_top_test.sv
// Self-checking bench of the status register, protection and reset sequence.
`timescale 1ns/10ps
module flsr_top_test
  import flsr_pkg::*;
;
  // A short erase keeps the run brief yet outlasts two one-byte frames.
  localparam int P_ERASE = 400;
  logic i_clk, i_rst_n, i_cs_n, i_sclk, i_si, i_wp_n_lane2, i_addr_4byte;
  logic o_so, o_so_oe, o_lane23_data, o_fast_mode_off, o_op_start, o_mem_reset;
  logic [7:0] o_status;
  logic [31:0] o_op_addr;
  flsr_op_t o_op_kind;
  logic [63:0] rd;
  int failures, n_checks, n_start, n_rst, n_oe;

  flsr_top #(.P_ERASE_CYCLES(P_ERASE)) i_flsr_top (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_si(i_si),
    .i_wp_n_lane2(i_wp_n_lane2), .o_so(o_so), .o_so_oe(o_so_oe), .i_addr_4byte(i_addr_4byte),
    .o_status(o_status), .o_lane23_data(o_lane23_data), .o_fast_mode_off(o_fast_mode_off),
    .o_op_start(o_op_start), .o_op_kind(o_op_kind), .o_op_addr(o_op_addr),
    .o_mem_reset(o_mem_reset)
  );
  flsr_host i_flsr_host (
    .i_clk(i_clk), .i_so(o_so), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_si(i_si)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_op_start === 1'b1) n_start <= n_start + 1;
    if (o_mem_reset === 1'b1) n_rst <= n_rst + 1;
    if (o_so_oe === 1'b1) n_oe <= n_oe + 1;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, msg, got, exp);
    end
  endtask
  task automatic cmd(input logic [63:0] tx, input int n);
    logic [63:0] dummy;
    i_flsr_host.frame(tx, n, dummy);
  endtask
  task automatic wait_idle;
    int k;
    for (k = 0; k < 2000 && o_status[ST_BUSY] !== 1'b0; k++) @(negedge i_clk);
    if (k == 2000) begin
      failures++;
      $display("[ERR] %0t busy never cleared", $time);
      test_done();
    end
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_wp_n_lane2 = 1'b1;
    i_addr_4byte = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clk);
    chk(o_status, 8'h00, "status after reset");
    cmd(64'h02_00_00_10_55, 5);
    chk(n_start, 0, "program without latch");
    i_flsr_host.frame(64'h90_00_00_00_00_00, 6, rd);
    chk(rd[15:0], {MFR_ID, DEV_ID}, "id from 00");
    i_flsr_host.frame(64'h90_00_00_01_00_00, 6, rd);
    chk(rd[15:0], {DEV_ID, MFR_ID}, "id from 01");
    chk({o_so_oe, n_oe != 0}, 2'b01, "output enable");
    cmd(64'h06, 1);
    chk(o_status, 8'h02, "latch set");
    i_flsr_host.frame(64'h05_00, 2, rd);
    chk(rd[7:0], 8'h02, "status read");
    cmd(64'h02_12_34_56_A5, 5);
    chk({n_start[7:0], o_op_kind, o_op_addr}, {8'h1, OP_PROG, 32'h0012_3456}, "program");
    chk(o_status[ST_BUSY], 1'b1, "busy in program");
    wait_idle();
    chk(o_status, 8'h00, "latch after program");
    i_addr_4byte = 1'b1;
    cmd(64'h06, 1);
    cmd(64'h20_01_23_45_67, 5);
    chk({n_start[7:0], o_op_kind, o_op_addr}, {8'h2, OP_SECT, 32'h0123_4567}, "4-byte erase");
    wait_idle();
    i_addr_4byte = 1'b0;
    cmd(64'h06, 1);
    cmd(64'h01_84, 2);
    chk(o_status[ST_BUSY], 1'b1, "busy in status write");
    wait_idle();
    chk(o_status, 8'h84, "status written");
    cmd(64'h06, 1);
    cmd(64'h02_FF_00_00_11, 5);
    chk({n_start, o_status}, {32'h2, 8'h84}, "protected program");
    cmd(64'h06, 1);
    cmd(64'h20_00_00_00, 4);
    chk(n_start, 3, "unprotected erase");
    wait_idle();
    cmd(64'h06, 1);
    cmd(64'h60, 1);
    chk({n_start, o_status}, {32'h3, 8'h84}, "chip erase refused");
    i_wp_n_lane2 = 1'b0;
    cmd(64'h06, 1);
    cmd(64'h01_00, 2);
    chk(o_status, 8'h86, "status write refused");
    i_wp_n_lane2 = 1'b1;
    cmd(64'h01_00, 2);
    wait_idle();
    chk(o_status, 8'h00, "status write with pin high");
    cmd(64'h06, 1);
    cmd(64'h60, 1);
    chk({n_start, o_op_kind}, {32'h4, OP_CE}, "chip erase");
    wait_idle();
    cmd(64'h06, 1);
    cmd(64'h38_00_00_00_11, 5);
    chk({n_start, o_lane23_data}, {32'h4, 1'b0}, "quad program refused");
    cmd(64'h06, 1);
    cmd(64'h01_40, 2);
    wait_idle();
    chk({o_status, o_lane23_data, o_fast_mode_off}, {8'h40, 2'h3}, "quad on");
    cmd(64'h06, 1);
    cmd(64'h38_00_00_00_11, 5);
    chk(n_start, 5, "quad program");
    wait_idle();
    cmd(64'h06, 1);
    cmd(64'h66, 1);
    cmd(64'h05, 1);
    cmd(64'h99, 1);
    chk({n_rst, o_status}, {32'h0, 8'h42}, "reset disarmed");
    cmd(64'h20_00_00_00, 4);
    cmd(64'h66, 1);
    cmd(64'h99, 1);
    chk({n_rst, o_status}, {32'h1, 8'h40}, "reset in erase");
    test_done();
  end
endmodule
